/* common/pbm_pkg.sv */
// Purpose: constants for the port b pin function mux (second uart)
// Assumes: 16-bit register address, 8-bit data, one clock
// Notes:   one bit per pin in every port register
//
// Contract
// - each of the six port registers holds one bit per pin, bit n for pin n.
// - pin 4 with both function-select bits 1 carries the uart transmit output.
// - pin 1 with both function-select bits 1 carries the uart transmit output.
// - pin 3 with select high 1 and select low 0 carries the uart transmit output.
// - pin 2 with both function-select bits 0 uses its primary function, uart receive.
// - pin 7 with both function-select bits 0 uses its primary function, uart receive.
// - pin 4 is a push-pull output when drive-mode high and low are 1 and direction is 0.
// - pin 1 is a push-pull output when drive-mode high and low are 1 and direction is 0.
// - pin 3 is a push-pull output when drive-mode high and low are 1 and direction is 0.
// - direction bit 1 on pin 2 makes that pin an input.
// - direction bit 1 on pin 7 makes that pin an input.
// - while a pin serves the uart its output-data bit has no effect.
// - receive-select bit 4 of the uart mode register picks pin 2 (0, reset) or pin 7 (1).
// - with receive-select 0 the receive comes from pin 2 even if pin 7 is set up for it.
package pbm_pkg;
  localparam int          PBM_AW          = 16;
  localparam int          PBM_DW          = 8;
  localparam int          PBM_NPIN        = 8;
  localparam logic [15:0] PBM_OFS_DATA    = 16'hf258;
  localparam logic [15:0] PBM_OFS_DIR     = 16'hf259;
  localparam logic [15:0] PBM_OFS_DRV_LO  = 16'hf25a;
  localparam logic [15:0] PBM_OFS_DRV_HI  = 16'hf25b;
  localparam logic [15:0] PBM_OFS_FUN_LO  = 16'hf25c;
  localparam logic [15:0] PBM_OFS_FUN_HI  = 16'hf25d;
  localparam logic [15:0] PBM_OFS_UMODE   = 16'hf25e;
  localparam int          PBM_RSEL_BIT    = 4;
  localparam logic [7:0]  PBM_RST_DATA    = 8'h00;
  localparam logic [7:0]  PBM_RST_DIR     = 8'h00;
  localparam logic [7:0]  PBM_RST_DRV     = 8'h00;
  localparam logic [7:0]  PBM_RST_FUN     = 8'h00;
  localparam logic [7:0]  PBM_RST_UMODE   = 8'h00;
  localparam int          PBM_PIN_TX_A    = 4;
  localparam int          PBM_PIN_TX_B    = 1;
  localparam int          PBM_PIN_TX_C    = 3;
  localparam int          PBM_PIN_RX_A    = 2;
  localparam int          PBM_PIN_RX_B    = 7;
  // function-select codes {high, low}
  typedef enum logic [1:0] {
    PBM_FN_PRIMARY  = 2'b00,
    PBM_FN_SECOND   = 2'b01,
    PBM_FN_TERTIARY = 2'b10,
    PBM_FN_FOURTH   = 2'b11
  } pbm_fn_t;
endpackage : pbm_pkg

/* core/pbm_top.sv */
// Purpose: port b pin function mux routing the second uart onto pins
// Assumes: synchronous inputs, pad logic outside resolves the pin wire
// Notes:   reads return data one cycle after the read strobe
module pbm_top (
  input  wire logic                         clk_in,          // system clock
  input  wire logic                         rst_in,          // sync reset, high
  input  wire logic [pbm_pkg::PBM_AW-1:0]   addr_in,         // register address
  input  wire logic [pbm_pkg::PBM_DW-1:0]   wdata_in,        // write data
  input  wire logic                         wr_in,           // write strobe
  input  wire logic                         rd_in,           // read strobe
  output logic      [pbm_pkg::PBM_DW-1:0]   rdata_out,       // read data
  input  wire logic [pbm_pkg::PBM_NPIN-1:0] pin_in,          // pad levels
  output logic      [pbm_pkg::PBM_NPIN-1:0] pin_out,         // pad drive value
  output logic      [pbm_pkg::PBM_NPIN-1:0] pin_oe_out,      // pad drive enable
  input  wire logic                         uart_tx_in,      // uart serial out
  output logic                              uart_rx_out      // uart serial in
);
  import pbm_pkg::*;

  logic [7:0] data_q, data_d;
  logic [7:0] dir_q, dir_d;
  logic [7:0] drv_lo_q, drv_lo_d;
  logic [7:0] drv_hi_q, drv_hi_d;
  logic [7:0] fun_lo_q, fun_lo_d;
  logic [7:0] fun_hi_q, fun_hi_d;
  logic [7:0] umode_q, umode_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] pin_q, pin_d;
  logic [7:0] oe_q, oe_d;
  logic       rx_q, rx_d;
  logic [7:0] tx_sel;
  logic [7:0] rx_ok;
  logic       tx_use;

  // register writes and read data
  always_comb begin
    data_d   = data_q;
    dir_d    = dir_q;
    drv_lo_d = drv_lo_q;
    drv_hi_d = drv_hi_q;
    fun_lo_d = fun_lo_q;
    fun_hi_d = fun_hi_q;
    umode_d  = umode_q;
    rdata_d  = 8'h00;
    if (wr_in) begin
      case (addr_in)
        PBM_OFS_DATA:   data_d   = wdata_in;
        PBM_OFS_DIR:    dir_d    = wdata_in;
        PBM_OFS_DRV_LO: drv_lo_d = wdata_in;
        PBM_OFS_DRV_HI: drv_hi_d = wdata_in;
        PBM_OFS_FUN_LO: fun_lo_d = wdata_in;
        PBM_OFS_FUN_HI: fun_hi_d = wdata_in;
        PBM_OFS_UMODE:  umode_d  = wdata_in;
        default: ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        PBM_OFS_DATA:   rdata_d = data_q;
        PBM_OFS_DIR:    rdata_d = dir_q;
        PBM_OFS_DRV_LO: rdata_d = drv_lo_q;
        PBM_OFS_DRV_HI: rdata_d = drv_hi_q;
        PBM_OFS_FUN_LO: rdata_d = fun_lo_q;
        PBM_OFS_FUN_HI: rdata_d = fun_hi_q;
        PBM_OFS_UMODE:  rdata_d = umode_q;
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_q   <= PBM_RST_DATA;
      dir_q    <= PBM_RST_DIR;
      drv_lo_q <= PBM_RST_DRV;
      drv_hi_q <= PBM_RST_DRV;
      fun_lo_q <= PBM_RST_FUN;
      fun_hi_q <= PBM_RST_FUN;
      umode_q  <= PBM_RST_UMODE;
      rdata_q  <= 8'h00;
    end else begin
      data_q   <= data_d;
      dir_q    <= dir_d;
      drv_lo_q <= drv_lo_d;
      drv_hi_q <= drv_hi_d;
      fun_lo_q <= fun_lo_d;
      fun_hi_q <= fun_hi_d;
      umode_q  <= umode_d;
      rdata_q  <= rdata_d;
    end
  end

  // transmit route per pin
  always_comb begin
    tx_sel = 8'h00;
    tx_sel[PBM_PIN_TX_A] = {fun_hi_q[PBM_PIN_TX_A], fun_lo_q[PBM_PIN_TX_A]}
                           == PBM_FN_FOURTH;
    tx_sel[PBM_PIN_TX_B] = {fun_hi_q[PBM_PIN_TX_B], fun_lo_q[PBM_PIN_TX_B]}
                           == PBM_FN_FOURTH;
    tx_sel[PBM_PIN_TX_C] = {fun_hi_q[PBM_PIN_TX_C], fun_lo_q[PBM_PIN_TX_C]}
                           == PBM_FN_TERTIARY;
  end

  // receive-capable pins: primary function and input direction
  always_comb begin
    rx_ok = 8'h00;
    rx_ok[PBM_PIN_RX_A] = ({fun_hi_q[PBM_PIN_RX_A], fun_lo_q[PBM_PIN_RX_A]}
                           == PBM_FN_PRIMARY) && dir_q[PBM_PIN_RX_A];
    rx_ok[PBM_PIN_RX_B] = ({fun_hi_q[PBM_PIN_RX_B], fun_lo_q[PBM_PIN_RX_B]}
                           == PBM_FN_PRIMARY) && dir_q[PBM_PIN_RX_B];
  end

  // pad drive: push-pull when both drive bits set and direction output
  generate
    for (genvar i = 0; i < PBM_NPIN; i++) begin : g_pin
      always_comb begin
        oe_d[i]  = drv_hi_q[i] && drv_lo_q[i] && !dir_q[i];
        pin_d[i] = tx_sel[i] ? uart_tx_in : data_q[i];
      end
    end
  endgenerate

  // receive select; drive mode of input pins is software's choice
  always_comb begin
    if (umode_q[PBM_RSEL_BIT]) begin
      rx_d = rx_ok[PBM_PIN_RX_B] ? pin_in[PBM_PIN_RX_B] : 1'b1;
    end else begin
      rx_d = rx_ok[PBM_PIN_RX_A] ? pin_in[PBM_PIN_RX_A] : 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_q <= 8'h00;
      oe_q  <= 8'h00;
      rx_q  <= 1'b1;
    end else begin
      pin_q <= pin_d;
      oe_q  <= oe_d;
      rx_q  <= rx_d;
    end
  end

  assign tx_use     = |tx_sel;
  assign rdata_out  = rdata_q;
  assign pin_out    = pin_q;
  assign pin_oe_out = oe_q;
  assign uart_rx_out = rx_q;

  a_tx_pin4: assert property (@(posedge clk_in) disable iff (rst_in)
    (fun_hi_q[4] && fun_lo_q[4]) |=> (pin_out[4] == $past(uart_tx_in)))
    else $error("pin 4 not carrying uart transmit");
  a_tx_pin1: assert property (@(posedge clk_in) disable iff (rst_in)
    (fun_hi_q[1] && fun_lo_q[1]) |=> (pin_out[1] == $past(uart_tx_in)))
    else $error("pin 1 not carrying uart transmit");
  a_tx_pin3: assert property (@(posedge clk_in) disable iff (rst_in)
    (fun_hi_q[3] && !fun_lo_q[3]) |=> (pin_out[3] == $past(uart_tx_in)))
    else $error("pin 3 not carrying uart transmit");
  a_oe_pin4: assert property (@(posedge clk_in) disable iff (rst_in)
    (drv_hi_q[4] && drv_lo_q[4] && !dir_q[4]) |=> pin_oe_out[4])
    else $error("pin 4 not driven");
  a_oe_pin1: assert property (@(posedge clk_in) disable iff (rst_in)
    (drv_hi_q[1] && drv_lo_q[1] && !dir_q[1]) |=> pin_oe_out[1])
    else $error("pin 1 not driven");
  a_oe_pin3: assert property (@(posedge clk_in) disable iff (rst_in)
    (drv_hi_q[3] && drv_lo_q[3] && !dir_q[3]) |=> pin_oe_out[3])
    else $error("pin 3 not driven");
  a_in_pin2: assert property (@(posedge clk_in) disable iff (rst_in)
    dir_q[2] |=> !pin_oe_out[2])
    else $error("pin 2 driven while input");
  a_in_pin7: assert property (@(posedge clk_in) disable iff (rst_in)
    dir_q[7] |=> !pin_oe_out[7])
    else $error("pin 7 driven while input");
  a_rx_pin2: assert property (@(posedge clk_in) disable iff (rst_in)
    (!umode_q[4] && !fun_hi_q[2] && !fun_lo_q[2] && dir_q[2])
      |=> (uart_rx_out == $past(pin_in[2])))
    else $error("receive not from pin 2");
  a_rx_pin7: assert property (@(posedge clk_in) disable iff (rst_in)
    (umode_q[4] && !fun_hi_q[7] && !fun_lo_q[7] && dir_q[7])
      |=> (uart_rx_out == $past(pin_in[7])))
    else $error("receive not from pin 7");
  a_rx_ignore7: assert property (@(posedge clk_in) disable iff (rst_in)
    (!umode_q[4] && !rx_ok[2]) |=> uart_rx_out)
    else $error("pin 7 leaked into receive");
  a_data_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
    (tx_use && tx_sel[4] && $changed(data_q[4]) && $stable(uart_tx_in))
      |=> $stable(pin_out[4]))
    else $error("data bit affected uart pin");
  a_read_data: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_in && !wr_in && addr_in == PBM_OFS_DIR) |=> (rdata_out == $past(dir_q)))
    else $error("direction read wrong");

  // single-cycle register writes, as steps for the properties below
  sequence s_wr_data;
    wr_in && !rd_in && (addr_in == PBM_OFS_DATA);
  endsequence
  sequence s_wr_dir;
    wr_in && !rd_in && (addr_in == PBM_OFS_DIR);
  endsequence
  sequence s_wr_drv_lo;
    wr_in && !rd_in && (addr_in == PBM_OFS_DRV_LO);
  endsequence
  sequence s_wr_drv_hi;
    wr_in && !rd_in && (addr_in == PBM_OFS_DRV_HI);
  endsequence
  sequence s_wr_fun_lo;
    wr_in && !rd_in && (addr_in == PBM_OFS_FUN_LO);
  endsequence
  sequence s_wr_fun_hi;
    wr_in && !rd_in && (addr_in == PBM_OFS_FUN_HI);
  endsequence
  sequence s_wr_umode;
    wr_in && !rd_in && (addr_in == PBM_OFS_UMODE);
  endsequence
  // direction write that turns pin 4 into a driven output
  sequence s_dir_out4;
    s_wr_dir ##0 (!wdata_in[PBM_PIN_TX_A] && drv_hi_q[PBM_PIN_TX_A]
                  && drv_lo_q[PBM_PIN_TX_A]);
  endsequence

  a_wr_data: assert property (@(posedge clk_in) disable iff (rst_in)
    s_wr_data |=> (data_q == $past(wdata_in)))
    else $error("data register write lost");
  a_wr_dir: assert property (@(posedge clk_in) disable iff (rst_in)
    s_wr_dir |=> (dir_q == $past(wdata_in)))
    else $error("direction register write lost");
  a_wr_drv_lo: assert property (@(posedge clk_in) disable iff (rst_in)
    s_wr_drv_lo |=> (drv_lo_q == $past(wdata_in)))
    else $error("drive low register write lost");
  a_wr_drv_hi: assert property (@(posedge clk_in) disable iff (rst_in)
    s_wr_drv_hi |=> (drv_hi_q == $past(wdata_in)))
    else $error("drive high register write lost");
  a_wr_fun_lo: assert property (@(posedge clk_in) disable iff (rst_in)
    s_wr_fun_lo |=> (fun_lo_q == $past(wdata_in)))
    else $error("function low register write lost");
  a_wr_fun_hi: assert property (@(posedge clk_in) disable iff (rst_in)
    s_wr_fun_hi |=> (fun_hi_q == $past(wdata_in)))
    else $error("function high register write lost");
  a_wr_umode: assert property (@(posedge clk_in) disable iff (rst_in)
    s_wr_umode |=> (umode_q == $past(wdata_in)))
    else $error("uart mode register write lost");

  // pad enable follows a direction write two edges later
  a_dir_to_oe: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_dir_out4 ##1 1'b1) |=> pin_oe_out[PBM_PIN_TX_A])
    else $error("pin 4 enable did not follow direction write");

  // unmapped or absent reads return zero
  a_rd_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    !rd_in |=> (rdata_out == 8'h00))
    else $error("read data without read strobe");
  a_rd_unmapped: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_in && ((addr_in < PBM_OFS_DATA) || (addr_in > PBM_OFS_UMODE)))
      |=> (rdata_out == 8'h00))
    else $error("unmapped read not zero");

  // receive line idles high when the selected pin is not usable
  a_rx_idle7: assert property (@(posedge clk_in) disable iff (rst_in)
    (umode_q[PBM_RSEL_BIT] && !rx_ok[PBM_PIN_RX_B]) |=> uart_rx_out)
    else $error("receive not idle with pin 7 unusable");
  a_rx_pin2_out: assert property (@(posedge clk_in) disable iff (rst_in)
    (!umode_q[PBM_RSEL_BIT] && !dir_q[PBM_PIN_RX_A]) |=> uart_rx_out)
    else $error("receive taken from output pin 2");

  // output-data bit does not reach the other uart pins
  a_data_ign1: assert property (@(posedge clk_in) disable iff (rst_in)
    (tx_sel[PBM_PIN_TX_B] && $changed(data_q[PBM_PIN_TX_B]) && $stable(uart_tx_in))
      |=> $stable(pin_out[PBM_PIN_TX_B]))
    else $error("data bit affected pin 1");
  a_data_ign3: assert property (@(posedge clk_in) disable iff (rst_in)
    (tx_sel[PBM_PIN_TX_C] && $changed(data_q[PBM_PIN_TX_C]) && $stable(uart_tx_in))
      |=> $stable(pin_out[PBM_PIN_TX_C]))
    else $error("data bit affected pin 3");

  // reset state of outputs and receive select
  a_rst_state: assert property (@(posedge clk_in)
    rst_in |=> (!umode_q[PBM_RSEL_BIT] && uart_rx_out && (pin_oe_out == 8'h00)
                && (rdata_out == 8'h00)))
    else $error("reset state wrong");

  // per pin: non-uart pins show their data bit, enable only in push-pull mode
  generate
    for (genvar j = 0; j < PBM_NPIN; j++) begin : g_chk
      a_pin_data: assert property (@(posedge clk_in) disable iff (rst_in)
        !tx_sel[j] |=> (pin_out[j] == $past(data_q[j])))
        else $error("pin not showing its data bit");
      a_oe_off: assert property (@(posedge clk_in) disable iff (rst_in)
        !(drv_hi_q[j] && drv_lo_q[j] && !dir_q[j]) |=> !pin_oe_out[j])
        else $error("pin driven outside push-pull mode");
    end
  endgenerate

  // pins 2 and 7 never drive while inputs, whatever the drive bits hold
  a_in_free2: assert property (@(posedge clk_in) disable iff (rst_in)
    (dir_q[PBM_PIN_RX_A] && drv_hi_q[PBM_PIN_RX_A]) |=> !pin_oe_out[PBM_PIN_RX_A])
    else $error("input pin 2 driven");
  a_in_free7: assert property (@(posedge clk_in) disable iff (rst_in)
    (dir_q[PBM_PIN_RX_B] && drv_hi_q[PBM_PIN_RX_B]) |=> !pin_oe_out[PBM_PIN_RX_B])
    else $error("input pin 7 driven");
endmodule : pbm_top

/* tb/pbm_partner.sv */
// Purpose: far side of the pin mux: uart core transmit and external serial device
// Assumes: pad wire resolved here from the design's enables
// Notes:   undriven pads show a pattern that changes every cycle
module pbm_partner (
  input  wire logic       clk_in,        // system clock
  input  wire logic       rst_in,        // sync reset, high
  input  wire logic [7:0] pin_drv_in,    // design pad value
  input  wire logic [7:0] pin_oe_in,     // design pad enable
  output logic      [7:0] pin_level_out, // resolved pad levels
  output logic            uart_tx_out    // uart serial output
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lfsr_q;
  always @(posedge clk_in) begin
    if (rst_in)
      lfsr_q <= 16'hace1;
    else
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end
  // released pads never hold the last driven value
  assign pin_level_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & (lfsr_q[7:0] ^ lfsr_q[15:8]));
  assign uart_tx_out   = rst_in | lfsr_q[3];
endmodule : pbm_partner

/* tb/pbm_top_tb.sv */
// Purpose: self-checking bench for the port b uart pin mux
// Assumes: one clock, reads answered one cycle later
// Notes:   shadow registers predict pins, receive line and read data
module pbm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pbm_pkg::*;
  logic        clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic        uart_tx_in, uart_rx_out, exp_rx_q, rd_pend_q, live_q = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0]  wdata_in = 8'h00, rdata_out, pin_in, pin_out, pin_oe_out;
  logic [7:0]  regs_q [7];
  logic [7:0]  exp_out_q, exp_oe_q, exp_rd_q;
  int          fails = 0, n_checks = 0, seed = 20523;
  always #2.5 clk_in = ~clk_in;
  pbm_top i_pbm_top (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .uart_tx_in(uart_tx_in), .uart_rx_out(uart_rx_out));
  pbm_partner i_pbm_partner (.clk_in(clk_in), .rst_in(rst_in), .pin_drv_in(pin_out),
    .pin_oe_in(pin_oe_out), .pin_level_out(pin_in), .uart_tx_out(uart_tx_in));
  function automatic logic [1:0] fsel(input int n);
    return {regs_q[5][n], regs_q[4][n]};
  endfunction : fsel
  function automatic logic [7:0] exp_pins(input logic tx);
    logic [7:0] v;
    v = regs_q[0];
    if (fsel(PBM_PIN_TX_A) == PBM_FN_FOURTH) v[PBM_PIN_TX_A] = tx;
    if (fsel(PBM_PIN_TX_B) == PBM_FN_FOURTH) v[PBM_PIN_TX_B] = tx;
    if (fsel(PBM_PIN_TX_C) == PBM_FN_TERTIARY) v[PBM_PIN_TX_C] = tx;
    return v;
  endfunction : exp_pins
  function automatic logic exp_rx(input logic [7:0] lv);
    int p;
    p = regs_q[6][PBM_RSEL_BIT] ? PBM_PIN_RX_B : PBM_PIN_RX_A;
    return (fsel(p) == PBM_FN_PRIMARY && regs_q[1][p]) ? lv[p] : 1'b1;
  endfunction : exp_rx
  wire mapped = addr_in >= PBM_OFS_DATA && addr_in <= PBM_OFS_UMODE;
  always @(posedge clk_in) begin
    exp_out_q <= exp_pins(uart_tx_in);
    exp_oe_q  <= regs_q[3] & regs_q[2] & ~regs_q[1];
    exp_rx_q  <= exp_rx(pin_in);
    rd_pend_q <= rd_in & ~rst_in;
    exp_rd_q  <= mapped ? regs_q[int'(addr_in - PBM_OFS_DATA)] : 8'h00;
    live_q    <= ~rst_in;
    if (rst_in) begin
      for (int i = 0; i < 7; i++) regs_q[i] <= 8'h00;
    end else if (wr_in && mapped) begin
      regs_q[int'(addr_in - PBM_OFS_DATA)] <= wdata_in;
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  always @(negedge clk_in) begin
    if (live_q) begin
      check("pin_out", pin_out, exp_out_q);
      check("pin_oe_out", pin_oe_out, exp_oe_q);
      check("uart_rx_out", {7'h00, uart_rx_out}, {7'h00, exp_rx_q});
      check("rdata_out", rdata_out, rd_pend_q ? exp_rd_q : 8'h00);
    end
  end
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in    <= w;
    rd_in    <= r;
    addr_in  <= a;
    wdata_in <= d;
  endtask : bus
  task automatic sweep;
    for (int a = 0; a < 8; a++) bus(1'b0, 1'b1, PBM_OFS_DATA + 16'(a), 8'h00);
  endtask : sweep
  task automatic tally_and_finish;
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    int tx;
    int rx;
    logic [15:0] r;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    sweep();
    // the three transmit pins against receive pin 2, pins 4 and 1 against pin 7; last pass leaves select at 0
    for (int k = 0; k < 6; k++) begin
      tx = (k % 3 == 0) ? PBM_PIN_TX_A : (k % 3 == 1) ? PBM_PIN_TX_B : PBM_PIN_TX_C;
      rx = (k < 3) ? PBM_PIN_RX_A : PBM_PIN_RX_B;
      bus(1'b1, 1'b0, PBM_OFS_FUN_HI, 8'(1 << tx));
      bus(1'b1, 1'b0, PBM_OFS_FUN_LO, (tx == PBM_PIN_TX_C) ? 8'h00 : 8'(1 << tx));
      bus(1'b1, 1'b0, PBM_OFS_DRV_HI, 8'(1 << tx) | 8'($random(seed)));
      bus(1'b1, 1'b0, PBM_OFS_DRV_LO, 8'(1 << tx) | 8'($random(seed)));
      bus(1'b1, 1'b0, PBM_OFS_DIR, 8'(1 << rx) | ((k == 5) ? 8'h04 : 8'h00));
      bus(1'b1, 1'b0, PBM_OFS_DATA, 8'($random(seed)));
      bus(1'b1, 1'b0, PBM_OFS_UMODE, (k == 3 || k == 4) ? 8'h10 : 8'h00);
      repeat (24) bus(1'b0, 1'b1, PBM_OFS_DATA + 16'(k), 8'h00);
    end
    repeat (3000) begin
      r = 16'($random(seed));
      bus(r[1:0] == 2'b01, r[1], PBM_OFS_DATA + 16'(r[4:2]), r[15:8]);
    end
    bus(1'b0, 1'b0, PBM_OFS_DATA, 8'h00);
    rst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    sweep();
    repeat (4) bus(1'b0, 1'b0, PBM_OFS_DATA, 8'h00);
    tally_and_finish();
  end
endmodule : pbm_top_tb
